// ---- cos_slave.sv ----
// servo slave end: state sequence, sync-committed fast data, gated slow data, timeouts
`timescale 1ns/100ps
module cos_slave #(
    parameter int MS_CYCLES = cos_pkg::MS_CYCLES,
    parameter logic [63:0] SLOW_DEFAULT = 64'h0000_0000_0000_0000,
    // arbitrary identity values
    parameter logic [63:0] SERIAL_NUM = 64'h0000_0000_0000_1234,
    parameter logic [63:0] PART_NUM = 64'h0000_0000_0000_5678
) (
    input wire logic clk,
    input wire logic reset_n,
    cos_link_if.slave link,
    input wire logic [4:0] node_id,
    input wire logic [14:0] timeout_ms,
    input wire logic [119:0] reply_data,
    input wire logic [63:0] slow_status,
    output logic [39:0] fast_active,
    output logic [63:0] slow_param,
    output logic slow_enabled,
    output logic operational,
    output logic comm_fault
);
    typedef enum logic [1:0] {
        ST_INIT,
        ST_PREOP,
        ST_OP
    } cos_state_e;

    cos_state_e state_q;
    logic [4:0] init_cnt_q;
    logic [15:0] ms_cnt_q;
    logic ms_tick;
    logic slow_ms_q;
    logic [14:0] sync_age_q;
    logic [14:0] fast_age_q;
    logic saw_sync_q;
    logic saw_fast_q;
    logic [39:0] fast_hold_q;
    logic [119:0] reply_q;
    logic boot_pend_q;
    logic [1:0] fast_pend_q;
    logic slow_pend_q;
    logic sdo_pend_q;
    logic [7:0] sdo_obj_q;
    logic op;
    logic rx_me;
    logic rx_all;
    logic rx_start;
    logic rx_sync;
    logic rx_fast;
    logic rx_slow;
    logic rx_sdo;
    logic err;
    logic push;
    logic push_ready;
    cos_pkg::cos_msg_s push_msg;
    logic [cos_pkg::MSG_W-1:0] tx_word;

    assign op = state_q == ST_OP;
    assign operational = op;
    // node 0 is the broadcast address, slaves use 1..31
    assign rx_me = link.m_valid && (link.m_msg.node == node_id) && (node_id != cos_pkg::NODE_ALL);
    assign rx_all = link.m_valid && (link.m_msg.node == cos_pkg::NODE_ALL);
    assign rx_start = rx_all && (link.m_msg.kind == cos_pkg::MSG_START);
    assign rx_sync = op && rx_all && (link.m_msg.kind == cos_pkg::MSG_SYNC);
    assign rx_fast = op && rx_me && (link.m_msg.kind == cos_pkg::MSG_FAST);
    assign rx_slow = op && rx_me && (link.m_msg.kind == cos_pkg::MSG_SLOW);
    assign rx_sdo = op && rx_me && (link.m_msg.kind == cos_pkg::MSG_SDO);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= ST_INIT;
            init_cnt_q <= '0;
        end else begin
            unique case (state_q)
                ST_INIT: begin
                    init_cnt_q <= init_cnt_q + 5'h01;
                    if (init_cnt_q == 5'(cos_pkg::INIT_CYCLES - 1)) begin
                        state_q <= ST_PREOP;
                    end
                end
                ST_PREOP: begin
                    if (rx_start) begin
                        state_q <= ST_OP;
                    end
                end
                ST_OP: begin
                    state_q <= ST_OP;
                end
            endcase
        end
    end

    // millisecond enable and 2 ms slow tick
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ms_cnt_q <= '0;
            slow_ms_q <= 1'b0;
        end else if (ms_tick) begin
            ms_cnt_q <= '0;
            slow_ms_q <= !slow_ms_q;
        end else begin
            ms_cnt_q <= ms_cnt_q + 16'h0001;
        end
    end
    assign ms_tick = ms_cnt_q == 16'(MS_CYCLES - 1);

    // fast data is held on receipt, committed only on sync
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            fast_hold_q <= '0;
            fast_active <= '0;
            reply_q <= '0;
        end else begin
            if (rx_fast) begin
                fast_hold_q <= link.m_msg.data[8*cos_pkg::FAST_RX_BYTES-1:0];
            end
            if (rx_sync) begin
                fast_active <= fast_hold_q;
                reply_q <= (fast_pend_q == 2'h1) ? reply_q : reply_data;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            slow_param <= SLOW_DEFAULT;
            slow_enabled <= 1'b0;
        end else if (rx_slow) begin
            slow_param <= link.m_msg.data;
            slow_enabled <= 1'b1;
        end
    end

    // arrival ages in ms, cleared on each receipt
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sync_age_q <= '0;
            fast_age_q <= '0;
        end else if (!op) begin
            sync_age_q <= '0;
            fast_age_q <= '0;
        end else begin
            if (rx_sync) begin
                sync_age_q <= '0;
            end else if (ms_tick) begin
                sync_age_q <= cos_pkg::age_inc(sync_age_q);
            end
            if (rx_fast) begin
                fast_age_q <= '0;
            end else if (ms_tick) begin
                fast_age_q <= cos_pkg::age_inc(fast_age_q);
            end
        end
    end

    // a zero timeout disables detection; values above the maximum are clamped
    always_comb begin
        logic [14:0] lim;
        lim = (timeout_ms > 15'(cos_pkg::TIMEOUT_MAX_MS)) ? 15'(cos_pkg::TIMEOUT_MAX_MS) : timeout_ms;
        err = op && (cos_pkg::aged_out(sync_age_q, lim) || cos_pkg::aged_out(fast_age_q, lim));
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            comm_fault <= 1'b0;
            saw_sync_q <= 1'b0;
            saw_fast_q <= 1'b0;
        end else if (err) begin
            comm_fault <= 1'b1;
            saw_sync_q <= 1'b0;
            saw_fast_q <= 1'b0;
        end else begin
            if (rx_sync) begin
                saw_sync_q <= 1'b1;
            end
            if (rx_fast) begin
                saw_fast_q <= 1'b1;
            end
            if (saw_sync_q && saw_fast_q) begin
                comm_fault <= 1'b0;
            end
        end
    end

    // transmit arbitration: fast reply, boot, SDO, slow
    always_comb begin
        push = 1'b1;
        push_msg.node = node_id;
        push_msg.kind = cos_pkg::MSG_FAST;
        push_msg.len = cos_pkg::LEN_FRAME1;
        push_msg.data = reply_q[119:56];
        if (fast_pend_q == 2'h2) begin
            push_msg.data = reply_q[119:56];
        end else if (fast_pend_q == 2'h1) begin
            push_msg.len = cos_pkg::LEN_FRAME2;
            push_msg.data = {8'h00, reply_q[55:0]};
        end else if (boot_pend_q) begin
            push_msg.kind = cos_pkg::MSG_BOOT;
            push_msg.len = 4'h0;
            push_msg.data = '0;
        end else if (sdo_pend_q) begin
            push_msg.kind = cos_pkg::MSG_SDO;
            push_msg.data = (sdo_obj_q == 8'h00) ? SERIAL_NUM : PART_NUM;
        end else if (slow_pend_q) begin
            push_msg.kind = cos_pkg::MSG_SLOW;
            push_msg.len = 4'(cos_pkg::SLOW_BYTES);
            push_msg.data = slow_status;
        end else begin
            push = 1'b0;
        end
    end

    // pending flags: set wins; a sync never splits a reply pair whose second half still waits
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            boot_pend_q <= 1'b0;
            fast_pend_q <= '0;
            slow_pend_q <= 1'b0;
            sdo_pend_q <= 1'b0;
            sdo_obj_q <= '0;
        end else begin
            // boot-up is the only heartbeat, raised once on leaving init
            if (state_q == ST_INIT && init_cnt_q == 5'(cos_pkg::INIT_CYCLES - 1)) begin
                boot_pend_q <= 1'b1;
            end else if (push_ready && fast_pend_q == 2'h0 && boot_pend_q) begin
                boot_pend_q <= 1'b0;
            end
            if (rx_sync && fast_pend_q != 2'h1) begin
                fast_pend_q <= 2'h2;
            end else if (push_ready && fast_pend_q != 2'h0) begin
                fast_pend_q <= fast_pend_q - 2'h1;
            end
            if (rx_sdo) begin
                sdo_pend_q <= 1'b1;
                sdo_obj_q <= link.m_msg.data[7:0];
            end else if (push_ready && push_msg.kind == cos_pkg::MSG_SDO) begin
                sdo_pend_q <= 1'b0;
            end
            if (op && slow_enabled && ms_tick && slow_ms_q) begin
                slow_pend_q <= 1'b1;
            end else if (push_ready && push_msg.kind == cos_pkg::MSG_SLOW) begin
                slow_pend_q <= 1'b0;
            end
        end
    end

    logic fifo_in_ready;
    assign push_ready = push && fifo_in_ready;

    cos_fifo #(
        .W(cos_pkg::MSG_W),
        .DEPTH(cos_pkg::FIFO_DEPTH)
    ) u_tx_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(push_msg),
        .out_valid(link.s_valid),
        .out_ready(link.s_ready),
        .out_data(tx_word)
    );
    assign link.s_msg = tx_word;
endmodule : cos_slave

// ---- cos_pkg.sv ----
// shared constants and message types for the servo slave link
package cos_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int MS_CYCLES = CLK_HZ / 1000;
    localparam int INIT_CYCLES = 16;
    localparam int SLOW_TICK_MS = 2;
    localparam int FRAME_MS = 10;
    localparam int START_PERIOD_MS = 1000;
    localparam int SDO_TIMEOUT_MS = 1000;
    localparam int SLOW_WINDOW_MS = 75;
    localparam int SLOW_TO_SLAVE = 4;
    localparam int TIMEOUT_MAX_MS = 30000;
    localparam int MAX_NODES = 31;
    localparam int MAX_SLAVES = 10;
    localparam int FAST_RX_BYTES = 5;
    localparam int FAST_TX_BYTES = 15;
    localparam int SYNC_BYTES = 1;
    localparam int SLOW_BYTES = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int SDO_OBJECTS = 2;
    localparam logic [4:0] NODE_ALL = 5'h00;
    localparam logic [3:0] LEN_FRAME1 = 4'h8;
    localparam logic [3:0] LEN_FRAME2 = 4'h7;

    typedef enum logic [2:0] {
        MSG_START,
        MSG_SYNC,
        MSG_FAST,
        MSG_SLOW,
        MSG_SDO,
        MSG_BOOT
    } cos_kind_e;

    typedef struct packed {
        cos_kind_e kind;
        logic [4:0] node;
        logic [3:0] len;
        logic [63:0] data;
    } cos_msg_s;

    localparam int MSG_W = $bits(cos_msg_s);

    // saturating millisecond age counter
    function automatic logic [14:0] age_inc(input logic [14:0] v);
        return (v == 15'h7FFF) ? v : v + 15'h0001;
    endfunction : age_inc

    // age has reached a nonzero timeout
    function automatic logic aged_out(input logic [14:0] age, input logic [14:0] lim);
        return (lim != 15'h0000) && (age >= lim);
    endfunction : aged_out
endpackage : cos_pkg

// ---- cos_link_if.sv ----
// message level link between network master and servo slave
`timescale 1ns/100ps
interface cos_link_if;
    cos_pkg::cos_msg_s m_msg;
    logic m_valid;
    cos_pkg::cos_msg_s s_msg;
    logic s_valid;
    logic s_ready;
    modport master (output m_msg, output m_valid, input s_msg, input s_valid, output s_ready);
    modport slave (input m_msg, input m_valid, output s_msg, output s_valid, input s_ready);
endinterface : cos_link_if

// ---- cos_fifo.sv ----
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/100ps
module cos_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic push;
    logic pop;

    assign in_ready = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
    assign out_valid = wr_q != rd_q;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule : cos_fifo

// ---- cos_master.sv ----
// network master end: start broadcasts, identity reads, frame traffic, slow pacing
`timescale 1ns/100ps
module cos_master #(
    parameter int MS_CYCLES = cos_pkg::MS_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    cos_link_if.master link,
    input wire logic [3:0] num_slaves,
    input wire logic [39:0] fast_demand,
    input wire logic [63:0] slow_cmd,
    input wire logic [14:0] timeout_ms,
    input wire logic rx_stall,
    output logic operational,
    output logic [9:0] slave_fault,
    output logic [63:0] id_data,
    output logic [4:0] id_node,
    output logic id_valid,
    output logic sdo_busy
);
    logic [15:0] ms_cnt_q;
    logic ms_tick;
    logic [9:0] start_ms_q;
    logic [3:0] frame_ms_q;
    logic [6:0] win_ms_q;
    logic start_pend_q;
    logic fast_run_q;
    logic [4:0] fast_idx_q;
    logic sdo_todo_q;
    logic [4:0] sdo_node_q;
    logic [7:0] sdo_obj_q;
    logic [9:0] sdo_age_q;
    logic slow_pend_q;
    logic [4:0] slow_node_q;
    logic [2:0] slow_sent_q;
    logic [14:0] age_q [cos_pkg::MAX_SLAVES];
    logic rx;
    logic sdo_end;
    logic sdo_hit;
    logic [4:0] last_node;
    cos_pkg::cos_msg_s tx;
    logic tx_valid;

    assign ms_tick = ms_cnt_q == 16'(MS_CYCLES - 1);
    assign rx = link.s_valid && link.s_ready;
    assign link.s_ready = !rx_stall;
    assign last_node = (num_slaves > 4'(cos_pkg::MAX_SLAVES)) ? 5'(cos_pkg::MAX_SLAVES) : {1'b0, num_slaves};
    assign sdo_hit = rx && link.s_msg.kind == cos_pkg::MSG_SDO && link.s_msg.node == sdo_node_q;
    assign sdo_end = sdo_busy && (sdo_hit || sdo_age_q == 10'(cos_pkg::SDO_TIMEOUT_MS));

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ms_cnt_q <= '0;
            start_ms_q <= '0;
            frame_ms_q <= '0;
        end else begin
            ms_cnt_q <= ms_tick ? 16'h0000 : ms_cnt_q + 16'h0001;
            if (ms_tick) begin
                start_ms_q <= (start_ms_q == 10'(cos_pkg::START_PERIOD_MS - 1)) ? 10'h000 : start_ms_q + 10'h001;
                frame_ms_q <= (frame_ms_q == 4'(cos_pkg::FRAME_MS - 1)) ? 4'h0 : frame_ms_q + 4'h1;
            end
        end
    end

    // transmit priority: frame burst, start, SDO request, slow
    always_comb begin
        tx_valid = 1'b1;
        tx.kind = cos_pkg::MSG_START;
        tx.node = cos_pkg::NODE_ALL;
        tx.len = 4'h2;
        tx.data = '0;
        if (fast_run_q && fast_idx_q <= last_node) begin
            tx.kind = cos_pkg::MSG_FAST;
            tx.node = fast_idx_q;
            tx.len = 4'(cos_pkg::FAST_RX_BYTES);
            tx.data = {24'h000000, fast_demand};
        end else if (fast_run_q) begin
            tx.kind = cos_pkg::MSG_SYNC;
            tx.len = 4'(cos_pkg::SYNC_BYTES);
        end else if (start_pend_q) begin
            tx.kind = cos_pkg::MSG_START;
        end else if (sdo_todo_q && !sdo_busy) begin
            tx.kind = cos_pkg::MSG_SDO;
            tx.node = sdo_node_q;
            tx.data = {56'h0, sdo_obj_q};
        end else if (slow_pend_q) begin
            tx.kind = cos_pkg::MSG_SLOW;
            tx.node = slow_node_q;
            tx.len = 4'(cos_pkg::SLOW_BYTES);
            tx.data = slow_cmd;
        end else begin
            tx_valid = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            link.m_valid <= 1'b0;
            link.m_msg <= '0;
        end else begin
            link.m_valid <= tx_valid;
            link.m_msg <= tx;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            operational <= 1'b0;
            start_pend_q <= 1'b1;
            fast_run_q <= 1'b0;
            fast_idx_q <= 5'h01;
        end else begin
            // own start broadcast makes the master operational
            if (tx_valid && tx.kind == cos_pkg::MSG_START) begin
                operational <= 1'b1;
            end
            if (operational && ms_tick && start_ms_q == 10'(cos_pkg::START_PERIOD_MS - 1)) begin
                start_pend_q <= 1'b1;
            end else if (tx_valid && tx.kind == cos_pkg::MSG_START) begin
                start_pend_q <= 1'b0;
            end
            if (operational && ms_tick && frame_ms_q == 4'(cos_pkg::FRAME_MS - 1)) begin
                fast_run_q <= 1'b1;
                fast_idx_q <= 5'h01;
            end else if (fast_run_q && fast_idx_q <= last_node) begin
                fast_idx_q <= fast_idx_q + 5'h01;
            end else begin
                fast_run_q <= 1'b0;
            end
        end
    end

    // identity reads, one request at a time
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sdo_todo_q <= 1'b0;
            sdo_busy <= 1'b0;
            sdo_node_q <= 5'h01;
            sdo_obj_q <= '0;
            sdo_age_q <= '0;
            id_valid <= 1'b0;
            id_data <= '0;
            id_node <= '0;
        end else begin
            id_valid <= 1'b0;
            if (!operational && tx_valid && tx.kind == cos_pkg::MSG_START) begin
                sdo_todo_q <= last_node != 5'h00;
                sdo_node_q <= 5'h01;
                sdo_obj_q <= '0;
            end else if (tx_valid && tx.kind == cos_pkg::MSG_SDO) begin
                sdo_busy <= 1'b1;
                sdo_age_q <= '0;
            end else if (sdo_end) begin
                sdo_busy <= 1'b0;
                if (sdo_hit) begin
                    id_valid <= 1'b1;
                    id_data <= link.s_msg.data;
                    id_node <= link.s_msg.node;
                end
                if (sdo_obj_q == 8'(cos_pkg::SDO_OBJECTS - 1)) begin
                    sdo_obj_q <= '0;
                    sdo_node_q <= sdo_node_q + 5'h01;
                    sdo_todo_q <= sdo_node_q < last_node;
                end else begin
                    sdo_obj_q <= sdo_obj_q + 8'h01;
                end
            end else if (sdo_busy && ms_tick) begin
                sdo_age_q <= sdo_age_q + 10'h001;
            end
        end
    end

    // slow window per slave: four messages 2 ms apart in a 75 ms slot
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            win_ms_q <= '0;
            slow_node_q <= 5'h01;
            slow_sent_q <= '0;
            slow_pend_q <= 1'b0;
        end else begin
            if (operational && ms_tick) begin
                if (win_ms_q == 7'(cos_pkg::SLOW_WINDOW_MS - 1)) begin
                    win_ms_q <= '0;
                    slow_sent_q <= '0;
                    slow_node_q <= (slow_node_q >= last_node) ? 5'h01 : slow_node_q + 5'h01;
                end else begin
                    win_ms_q <= win_ms_q + 7'h01;
                end
            end
            if (operational && ms_tick && win_ms_q[0] == 1'b0 && slow_sent_q < 3'(cos_pkg::SLOW_TO_SLAVE)
                && last_node != 5'h00) begin
                slow_pend_q <= 1'b1;
                slow_sent_q <= slow_sent_q + 3'h1;
            end else if (tx_valid && tx.kind == cos_pkg::MSG_SLOW) begin
                slow_pend_q <= 1'b0;
            end
        end
    end

    // per-slave fast reply age
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            slave_fault <= '0;
            for (int i = 0; i < cos_pkg::MAX_SLAVES; i++) begin
                age_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < cos_pkg::MAX_SLAVES; i++) begin
                if (rx && link.s_msg.kind == cos_pkg::MSG_FAST && link.s_msg.node == 5'(i + 1)) begin
                    age_q[i] <= '0;
                end else if (operational && ms_tick) begin
                    age_q[i] <= cos_pkg::age_inc(age_q[i]);
                end
                slave_fault[i] <= (5'(i + 1) <= last_node) && cos_pkg::aged_out(age_q[i], timeout_ms);
            end
        end
    end
endmodule : cos_master

// ---- cos_link_assertions.sv ----
// protocol checks on the link between the two ends
`timescale 1ns/100ps
module cos_link_assertions #(
    parameter int MS_CYCLES = 10
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire cos_pkg::cos_msg_s m_msg,
    input wire logic m_valid,
    input wire cos_pkg::cos_msg_s s_msg,
    input wire logic s_valid,
    input wire logic s_ready
);
    logic tk, mf, ms, mst, msd, msl, sb, sf, ssd, ssl, boot_q, op_q, slow_q, sdo_q;
    logic [15:0] age_q;
    assign tk = s_valid && s_ready;
    assign mf = m_valid && m_msg.kind == cos_pkg::MSG_FAST;
    assign ms = m_valid && m_msg.kind == cos_pkg::MSG_SYNC;
    assign mst = m_valid && m_msg.kind == cos_pkg::MSG_START;
    assign msd = m_valid && m_msg.kind == cos_pkg::MSG_SDO;
    assign msl = m_valid && m_msg.kind == cos_pkg::MSG_SLOW;
    assign sb = s_valid && s_msg.kind == cos_pkg::MSG_BOOT;
    assign sf = s_valid && s_msg.kind == cos_pkg::MSG_FAST;
    assign ssd = s_valid && s_msg.kind == cos_pkg::MSG_SDO;
    assign ssl = s_valid && s_msg.kind == cos_pkg::MSG_SLOW;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            boot_q <= 1'b0;
            op_q <= 1'b0;
            slow_q <= 1'b0;
        end else begin
            boot_q <= boot_q || (tk && sb);
            op_q <= op_q || (boot_q && mst);
            slow_q <= slow_q || (op_q && msl);
        end
    end
    // request in flight, given up a little before the master's own wait ends
    always_ff @(posedge clk) begin
        if (!reset_n || (tk && ssd) || age_q >= 16'(990 * MS_CYCLES)) begin
            sdo_q <= 1'b0;
        end else if (msd) begin
            sdo_q <= 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        age_q <= sdo_q ? age_q + 16'h0001 : 16'h0000;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    property p_boot_first; tk |-> boot_q || sb; endproperty
    a_boot_first: assert property (p_boot_first) else $error("word before boot");
    property p_one_boot; tk && sb |-> !boot_q; endproperty
    a_one_boot: assert property (p_one_boot) else $error("second boot");
    property p_sync_reply; ms && op_q |-> ##[1:12] (tk && sf || !s_ready); endproperty
    a_sync_reply: assert property (p_sync_reply) else $error("no fast reply");
    property p_pair; tk && sf && s_msg.len == cos_pkg::LEN_FRAME1 |=> sf && s_msg.len == cos_pkg::LEN_FRAME2; endproperty
    a_pair: assert property (p_pair) else $error("reply pair");
    property p_sync_next; mf |-> ##[1:10] ms; endproperty
    a_sync_next: assert property (p_sync_next) else $error("no sync");
    property p_bcast; mst || ms |-> m_msg.node == cos_pkg::NODE_ALL; endproperty
    a_bcast: assert property (p_bcast) else $error("not broadcast");
    property p_sdo_one; msd |-> !sdo_q; endproperty
    a_sdo_one: assert property (p_sdo_one) else $error("two requests");
    property p_slow_gate; ssl |-> slow_q; endproperty
    a_slow_gate: assert property (p_slow_gate) else $error("early slow");
    c_reply: cover property (tk && sf);
    c_sdo: cover property (tk && ssd);
    c_slow: cover property (tk && ssl);
endmodule : cos_link_assertions

// ---- tb.sv ----
// self-checking bench joining the master and slave ends
`timescale 1ns/100ps
module tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic rx_stall = 1'b0;
    logic arm = 1'b0;
    logic [3:0] num_slaves = 4'h1;
    logic [14:0] timeout_ms = 15'h001E;
    logic [31:0] lfsr = 32'h0000_0034;
    logic [39:0] fast_demand = 40'h00_0000_0000;
    logic [39:0] last_fa = 40'h00_0000_0000;
    logic [39:0] fast_active;
    logic [63:0] slow_cmd = 64'h0;
    logic [63:0] slow_param;
    logic [9:0] slave_fault;
    logic [63:0] id_data;
    logic [4:0] id_node;
    logic id_valid, sdo_busy;
    logic slow_enabled, s_op, m_op, comm_fault;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [63:0] exp_q[$];
    logic [63:0] id_q[$];
    cos_link_if u_cos_link_if();
    cos_master #(.MS_CYCLES(10)) u_cos_master (.clk(clk), .reset_n(reset_n), .link(u_cos_link_if.master),
        .num_slaves(num_slaves), .fast_demand(fast_demand), .slow_cmd(slow_cmd), .timeout_ms(timeout_ms),
        .rx_stall(rx_stall), .operational(m_op), .slave_fault(slave_fault), .id_data(id_data), .id_node(id_node),
        .id_valid(id_valid), .sdo_busy(sdo_busy));
    // identity values are arbitrary
    cos_slave #(.MS_CYCLES(10), .SLOW_DEFAULT(64'h0000_0000_0000_00C3), .SERIAL_NUM(64'h0000_0000_0000_00A5),
        .PART_NUM(64'h0000_0000_0000_005A)) u_cos_slave (.clk(clk), .reset_n(reset_n),
        .link(u_cos_link_if.slave), .node_id(5'h01), .timeout_ms(timeout_ms), .reply_data({3{fast_demand}}),
        .slow_status(slow_cmd), .fast_active(fast_active), .slow_param(slow_param),
        .slow_enabled(slow_enabled), .operational(s_op), .comm_fault(comm_fault));
    cos_link_assertions #(.MS_CYCLES(10)) u_cos_link_assertions (.clk(clk), .reset_n(reset_n),
        .m_msg(u_cos_link_if.m_msg), .m_valid(u_cos_link_if.m_valid), .s_msg(u_cos_link_if.s_msg),
        .s_valid(u_cos_link_if.s_valid), .s_ready(u_cos_link_if.s_ready));
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
        n_tests++;
        if (s !== e) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            end_sim();
        end
    end
    // committed demand is checked against the oldest value sent
    always @(negedge clk) begin
        if (arm && fast_active !== last_fa) begin
            chk("fast_active", exp_q.pop_front(), {24'h0, fast_active});
            last_fa = fast_active;
        end
    end
    always @(negedge clk) begin
        if (id_valid === 1'b1) begin
            chk("id_data", id_q.pop_front(), id_data);
            chk("id_node", 64'h1, {59'h0, id_node});
        end
    end
    initial begin
        // the serial request goes out while the slave still initialises and times out; only the part number returns
        id_q.push_back(64'h0000_0000_0000_005A);
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        chk("slow_param", 64'h0000_0000_0000_00C3, slow_param);
        chk("slow_enabled", 64'h0, {63'h0, slow_enabled});
        chk("master_op", 64'h1, {63'h0, m_op});
        chk("sdo_busy", 64'h1, {63'h0, sdo_busy});
        wait (s_op === 1'b1);
        repeat (20) @(negedge clk);
        arm = 1'b1;
        for (int i = 0; i < 4; i++) begin
            lfsr = nxt(lfsr);
            fast_demand = {lfsr[7:0], lfsr};
            slow_cmd = {lfsr, ~lfsr};
            exp_q.push_back({24'h0, fast_demand});
            repeat (250) @(negedge clk);
        end
        repeat (800) @(negedge clk);
        chk("slow_param", slow_cmd, slow_param);
        chk("slow_enabled", 64'h1, {63'h0, slow_enabled});
        chk("comm_fault", 64'h0, {63'h0, comm_fault});
        num_slaves = 4'h0;
        repeat (600) @(negedge clk);
        chk("comm_fault", 64'h1, {63'h0, comm_fault});
        num_slaves = 4'h1;
        rx_stall = 1'b1;
        repeat (600) @(negedge clk);
        chk("comm_fault", 64'h0, {63'h0, comm_fault});
        chk("slave_fault", 64'h1, {63'h0, slave_fault[0]});
        rx_stall = 1'b0;
        repeat (300) @(negedge clk);
        chk("fast_left", 64'h0, 64'(exp_q.size()));
        chk("sdo_busy", 64'h0, {63'h0, sdo_busy});
        chk("id_left", 64'h0, 64'(id_q.size()));
        end_sim();
    end
endmodule : tb
